// File: hw/otc_clock_ctrl.sv
//Function
// - Trim word is upper byte register bits plus two bits 6:5 of sysint.
// - Reset restores the upper trim register to all ones.
// - Trim code monotonic; zero is fastest, all ones slowest.
// - Two-bit startup option selects internal RC, wake-up RC or external.
// - In-circuit mode forces the internal RC as clock source.
// - Four factory trim bytes readable only in user mode, survive erase.
// - Request for wake-up RC clears Internal_osc_active_flag, holds system clock high.
// - Wait three wake-up RC cycles, then set the wake-up flag.
// - Switch to wake-up RC on its rising edge, then stop internal RC.
// - Clearing select counts eight internal RC cycles with 4-bit counter.
// - Then clear wake-up flag in one cycle, set Internal_osc_active_flag after two.
// - Switch back on internal RC rising edge, then stop wake-up RC.
// - Internal RC is stopped with the external clock and in state ST_ON_WU only.
// - With internal RC selected, halt wake-up turns wake-up RC on.
// - With external clock selected, wake-up RC always runs.
// - Clock out enable bit drives clock onto pin; clear on reset.
// - Slow mode bit divides the CPU clock by 32; clear on reset.
// - Switch register: select bit 0, flags bits 2 and 3, reset 09h.
//
// The placing of the registers and the APB slave port were decided locally.
module otc_clock_ctrl
    import otc_pkg::*;
#(
    parameter logic [7:0] FACTORY_TRIM_H0 = 8'h80,
    parameter logic [7:0] FACTORY_TRIM_L0 = 8'h00,
    parameter logic [7:0] FACTORY_TRIM_H1 = 8'h80,
    parameter logic [7:0] FACTORY_TRIM_L1 = 8'h00
) (
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Oscillators and device mode.
    input  wire logic              rcOscClk,
    input  wire logic              wakeupOscClk,
    input  wire logic              extClk,
    input  wire logic [1:0]        startupClockOption,
    input  wire logic              inCircuitCommMode,
    input  wire logic              userMode,
    input  wire logic              haltWakeupEntry,
    // Oscillator control.
    output logic      [9:0]        trimWord,
    output logic                   rcOscEnable,
    output logic                   wakeupOscEnable,
    // Clocks.
    output logic                   sysClk,
    output logic                   cpuClk,
    // Clock output pin.
    output logic                   clockOutPin,
    output logic                   clockOutPinOe
);

    // =========================================================
    // Reset release.
    logic rstnMeta;
    logic rstnSync;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstnMeta <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstnMeta <= 1'b1;
            rstnSync <= rstnMeta;
        end
    end

    // =========================================================
    // Oscillator taps.
    logic [OSC_N-1:0] oscIn;
    logic [OSC_N-1:0] oscLevel;
    logic [OSC_N-1:0] oscRise;

    assign oscIn[OSC_RC]  = rcOscClk;
    assign oscIn[OSC_WU]  = wakeupOscClk;
    assign oscIn[OSC_EXT] = extClk;

    genvar g;
    generate
        for (g = 0; g < OSC_N; g++) begin : gTap
            otc_osc_tap uTap (
                .ref_clk (ref_clk),
                .rstn    (rstnSync),
                .oscIn   (oscIn[g]),
                .level   (oscLevel[g]),
                .rise    (oscRise[g])
            );
        end
    endgenerate

    // =========================================================
    // APB decode.
    logic [7:0]  mainClockCtrl;
    logic [7:0]  rcTrimHigh;
    logic [1:0]  trimLowBits;
    logic        clockSourceSelect;
    logic        internalOscActiveFlag;
    logic        wakeupOscActiveFlag;
    logic        accessPhase;
    logic        wrEn;
    logic [15:0] regIdx;
    logic        addrAligned;
    logic        hitMain;
    logic        hitTrimHigh;
    logic        hitSysint;
    logic        hitSwitch;
    logic        hitFactory;
    logic [1:0]  factorySel;
    logic        mapped;
    logic [7:0]  next_readByte;

    assign accessPhase = psel & penable;
    assign wrEn        = accessPhase & pready & pwrite;
    assign regIdx      = paddr[ADDR_W-1:2];
    assign addrAligned = (paddr[1:0] == 2'h0);
    assign hitMain     = addrAligned & (regIdx == MAIN_CLOCK_CTRL_IDX);
    assign hitTrimHigh = addrAligned & (regIdx == RC_TRIM_HIGH_IDX);
    assign hitSysint   = addrAligned & (regIdx == SYSINT_CTRL_IDX);
    assign hitSwitch   = addrAligned & (regIdx == CLOCK_SWITCH_CTRL_IDX);
    assign hitFactory  = addrAligned & (regIdx[15:2] == FACTORY_TRIM_IDX[15:2]);
    assign factorySel  = regIdx[1:0];
    assign mapped      = hitMain | hitTrimHigh | hitSysint | hitSwitch
                       | (hitFactory & ~pwrite);

    // Factory trim bytes are constants and read as zero outside user mode.
    always_comb begin
        next_readByte = 8'h00;
        if (hitMain) begin
            next_readByte = mainClockCtrl;
        end else if (hitTrimHigh) begin
            next_readByte = rcTrimHigh;
        end else if (hitSysint) begin
            next_readByte[TRIM_LOW_MSB:TRIM_LOW_LSB] = trimLowBits;
        end else if (hitSwitch) begin
            next_readByte[SRC_SEL_BIT] = clockSourceSelect;
            next_readByte[INTERNAL_OSC_ACTIVE_FLAG_BIT] = internalOscActiveFlag;
            next_readByte[WU_FLAG_BIT] = wakeupOscActiveFlag;
        end else if (hitFactory && userMode) begin
            unique case (factorySel)
                2'h0: next_readByte = FACTORY_TRIM_H0;
                2'h1: next_readByte = FACTORY_TRIM_L0;
                2'h2: next_readByte = FACTORY_TRIM_H1;
                2'h3: next_readByte = FACTORY_TRIM_L1;
            endcase
        end
    end

    // =========================================================
    // APB answer: one wait cycle, then ready with data.
    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= accessPhase & ~pready;
            pslverr <= accessPhase & ~pready & ~mapped;
            if (accessPhase && !pready && !pwrite) begin
                prdata <= {24'h00_0000, next_readByte};
            end
        end
    end

    // =========================================================
    // Software registers.
    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            mainClockCtrl <= MAIN_CLOCK_CTRL_RST;
            rcTrimHigh    <= RC_TRIM_HIGH_RST;
            trimLowBits   <= TRIM_LOW_RST;
        end else if (wrEn) begin
            if (hitMain) begin
                mainClockCtrl <= {6'h00, pwdata[CLK_OUT_EN_BIT],
                                  pwdata[SLOW_MODE_BIT]};
            end
            if (hitTrimHigh) begin
                rcTrimHigh <= pwdata[7:0];
            end
            if (hitSysint) begin
                trimLowBits <= pwdata[TRIM_LOW_MSB:TRIM_LOW_LSB];
            end
        end
    end

    // Larger codes slow the RC monotonically; zero is the fastest.
    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            trimWord <= {RC_TRIM_HIGH_RST, TRIM_LOW_RST};
        end else begin
            trimWord <= {rcTrimHigh, trimLowBits};
        end
    end

    // =========================================================
    // Startup source capture.
    logic startupDone;
    logic srcExternal;
    logic iccLock;

    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            startupDone <= 1'b0;
            srcExternal <= 1'b0;
            iccLock     <= 1'b0;
        end else if (!startupDone) begin
            startupDone <= 1'b1;
            iccLock     <= inCircuitCommMode;
            srcExternal <= !inCircuitCommMode
                        && startupClockOption != OPT_INTERNAL_RC
                        && startupClockOption != OPT_WAKEUP_RC;
        end
    end

    // =========================================================
    // Clock switch sequencer.
    otc_state_t state;
    logic [3:0] cycleCnt;
    logic       wuCleared;
    logic       startRc;

    assign startRc = !inCircuitCommMode
                   && startupClockOption == OPT_INTERNAL_RC;

    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            state                 <= ST_ON_WU;
            clockSourceSelect     <= CLOCK_SWITCH_RST[SRC_SEL_BIT];
            internalOscActiveFlag <= CLOCK_SWITCH_RST[INTERNAL_OSC_ACTIVE_FLAG_BIT];
            wakeupOscActiveFlag   <= CLOCK_SWITCH_RST[WU_FLAG_BIT];
            cycleCnt              <= 4'h0;
            wuCleared             <= 1'b0;
        end else if (!startupDone) begin
            if (inCircuitCommMode || startRc) begin
                state                 <= ST_ON_RC;
                clockSourceSelect     <= 1'b0;
                internalOscActiveFlag <= 1'b1;
                wakeupOscActiveFlag   <= 1'b0;
            end
        end else begin
            if (wrEn && hitSwitch && !iccLock && !srcExternal) begin
                clockSourceSelect <= pwdata[SRC_SEL_BIT];
            end
            unique case (state)
                ST_ON_RC: begin
                    if (clockSourceSelect && !iccLock && !srcExternal) begin
                        state                 <= ST_TO_WU;
                        internalOscActiveFlag <= 1'b0;
                        cycleCnt              <= 4'h0;
                    end
                end
                ST_TO_WU: begin
                    if (oscRise[OSC_WU]) begin
                        if (cycleCnt == WU_SETTLE_CYCLES - 4'h1) begin
                            wakeupOscActiveFlag <= 1'b1;
                            state               <= ST_ON_WU;
                        end else begin
                            cycleCnt <= cycleCnt + 4'h1;
                        end
                    end
                end
                ST_ON_WU: begin
                    if (!clockSourceSelect) begin
                        state    <= ST_RC_CNT;
                        cycleCnt <= 4'h0;
                    end
                end
                ST_RC_CNT: begin
                    if (oscRise[OSC_RC]) begin
                        if (cycleCnt == RC_COUNT_CYCLES - 4'h1) begin
                            state     <= ST_INTERNAL_OSC_ACTIVE_FLAG;
                            cycleCnt  <= 4'h0;
                            wuCleared <= 1'b0;
                        end else begin
                            cycleCnt <= cycleCnt + 4'h1;
                        end
                    end
                end
                ST_INTERNAL_OSC_ACTIVE_FLAG: begin
                    if (!wuCleared && oscRise[OSC_WU]) begin
                        wakeupOscActiveFlag <= 1'b0;
                        wuCleared           <= 1'b1;
                    end
                    if (wuCleared && oscRise[OSC_RC]) begin
                        if (cycleCnt == INTERNAL_OSC_ACTIVE_FLAG_CYCLES - 4'h1) begin
                            internalOscActiveFlag <= 1'b1;
                            state                 <= ST_ON_RC;
                        end else begin
                            cycleCnt <= cycleCnt + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // =========================================================
    // Glitch-free system clock selection.
    logic next_sysClk;

    always_comb begin
        next_sysClk = 1'b1;
        if (srcExternal) begin
            next_sysClk = oscLevel[OSC_EXT];
        end else begin
            unique case (state)
                ST_ON_RC:   next_sysClk = oscLevel[OSC_RC];
                ST_TO_WU:   next_sysClk = 1'b1;
                ST_ON_WU:   next_sysClk = oscLevel[OSC_WU];
                ST_RC_CNT:  next_sysClk = oscLevel[OSC_WU];
                ST_INTERNAL_OSC_ACTIVE_FLAG: next_sysClk = oscLevel[OSC_WU] | wuCleared;
            endcase
        end
    end

    // =========================================================
    // Oscillator enables.
    logic rcSelected;

    assign rcSelected = !srcExternal && state == ST_ON_RC;

    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            rcOscEnable     <= 1'b0;
            wakeupOscEnable <= 1'b1;
        end else begin
            rcOscEnable     <= !srcExternal
                            && (state != ST_ON_WU || !startupDone);
            wakeupOscEnable <= srcExternal
                            || (state != ST_ON_RC)
                            || (rcSelected && haltWakeupEntry);
        end
    end

    // =========================================================
    // Slow mode divider and clock outputs.
    logic [3:0] divCnt;
    logic       slowClk;
    logic       sysRise;

    assign sysRise = next_sysClk & ~sysClk;

    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            divCnt  <= 4'h0;
            slowClk <= 1'b0;
        end else if (sysRise) begin
            divCnt <= divCnt + 4'h1;
            if (divCnt == SLOW_HALF_LAST) begin
                slowClk <= ~slowClk;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            sysClk        <= 1'b1;
            cpuClk        <= 1'b1;
            clockOutPin   <= 1'b0;
            clockOutPinOe <= 1'b0;
        end else begin
            sysClk        <= next_sysClk;
            cpuClk        <= mainClockCtrl[SLOW_MODE_BIT] ? slowClk
                                                          : next_sysClk;
            clockOutPinOe <= mainClockCtrl[CLK_OUT_EN_BIT];
            clockOutPin   <= mainClockCtrl[CLK_OUT_EN_BIT] & next_sysClk;
        end
    end

endmodule : otc_clock_ctrl

// File: hw/otc_pkg.sv
package otc_pkg;

    // =========================================================
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] MAIN_CLOCK_CTRL_IDX   = 16'h0038;
    localparam logic [15:0] RC_TRIM_HIGH_IDX      = 16'h0039;
    localparam logic [15:0] SYSINT_CTRL_IDX       = 16'h003A;
    localparam logic [15:0] CLOCK_SWITCH_CTRL_IDX = 16'h003F;
    localparam logic [15:0] FACTORY_TRIM_IDX      = 16'hDEE0;
    localparam int          FACTORY_TRIM_COUNT    = 4;
    localparam int          ADDR_W                = 18;

    // =========================================================
    // Field positions.
    localparam int SLOW_MODE_BIT   = 0;
    localparam int CLK_OUT_EN_BIT  = 1;
    localparam int TRIM_LOW_LSB    = 5;
    localparam int TRIM_LOW_MSB    = 6;
    localparam int SRC_SEL_BIT     = 0;
    localparam int INTERNAL_OSC_ACTIVE_FLAG_BIT     = 2;
    localparam int WU_FLAG_BIT     = 3;

    // =========================================================
    // Reset values.
    localparam logic [7:0] MAIN_CLOCK_CTRL_RST = 8'h00;
    localparam logic [7:0] RC_TRIM_HIGH_RST    = 8'hFF;
    localparam logic [1:0] TRIM_LOW_RST        = 2'h0;
    localparam logic [7:0] CLOCK_SWITCH_RST    = 8'h09;

    // =========================================================
    // Startup option codes.
    localparam logic [1:0] OPT_INTERNAL_RC = 2'h0;
    localparam logic [1:0] OPT_WAKEUP_RC   = 2'h1;

    // =========================================================
    // Switch timing in oscillator cycles.
    localparam logic [3:0] WU_SETTLE_CYCLES = 4'h3;
    localparam logic [3:0] RC_COUNT_CYCLES  = 4'h8;
    localparam logic [3:0] INTERNAL_OSC_ACTIVE_FLAG_CYCLES   = 4'h2;
    localparam int         SLOW_DIVIDE      = 32;
    localparam logic [3:0] SLOW_HALF_LAST   = 4'(SLOW_DIVIDE / 2 - 1);

    // =========================================================
    // Oscillator tap channels.
    localparam int OSC_RC  = 0;
    localparam int OSC_WU  = 1;
    localparam int OSC_EXT = 2;
    localparam int OSC_N   = 3;

    typedef enum logic [4:0] {
        ST_ON_RC   = 5'b00001,
        ST_TO_WU   = 5'b00010,
        ST_ON_WU   = 5'b00100,
        ST_RC_CNT  = 5'b01000,
        ST_INTERNAL_OSC_ACTIVE_FLAG = 5'b10000
    } otc_state_t;

endpackage : otc_pkg

// File: hw/otc_osc_tap.sv
module otc_osc_tap (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Oscillator level.
    input  wire logic oscIn,
    // Sampled level and rising-edge pulse.
    output logic      level,
    output logic      rise
);

    // =========================================================
    // Sampling and edge detection.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            level <= oscIn;
            rise  <= oscIn & ~level;
        end
    end

endmodule : otc_osc_tap

// File: bench/otc_clock_ctrl_props.sv
module otc_props
    import otc_pkg::*;
(
    // Clock and reset.
    input wire logic              ref_clk,
    input wire logic              rstn,
    // Register bus.
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Device mode.
    input wire logic [1:0]        startupClockOption,
    input wire logic              inCircuitCommMode,
    input wire logic              haltWakeupEntry,
    // Outputs watched.
    input wire logic [9:0]        trimWord,
    input wire logic              rcOscEnable,
    input wire logic              wakeupOscEnable,
    input wire logic              clockOutPin,
    input wire logic              clockOutPinOe
);

    // ==========
    // Write tracking.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    logic       acc;
    logic [9:0] trimSeen;

    assign acc = psel && penable && pready && pwrite;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            trimSeen <= 10'h3FC;
        end else if (acc && paddr[17:2] == RC_TRIM_HIGH_IDX) begin
            trimSeen[9:2] <= pwdata[7:0];
        end else if (acc && paddr[17:2] == SYSINT_CTRL_IDX) begin
            trimSeen[1:0] <= pwdata[6:5];
        end
    end

    sequence trimWr;
        acc && (paddr[17:2] == RC_TRIM_HIGH_IDX ||
                paddr[17:2] == SYSINT_CTRL_IDX);
    endsequence
    sequence pinOnWr;
        acc && paddr[17:2] == MAIN_CLOCK_CTRL_IDX && pwdata[1];
    endsequence
    sequence pinOffWr;
        acc && paddr[17:2] == MAIN_CLOCK_CTRL_IDX && !pwdata[1];
    endsequence

    // ==========
    // Assertions.
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel) && $past(penable))
        else $error("ready without access phase");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    read_upper_a: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    trim_match_a: assert property (trimWr |=> ##[0:2] trimWord == trimSeen)
        else $error("trim word mismatch");
    pin_on_a: assert property (pinOnWr |=> ##[0:2] clockOutPinOe)
        else $error("clock pin not enabled");
    pin_off_a: assert property (pinOffWr |=> ##[0:2] !clockOutPinOe && !clockOutPin)
        else $error("clock pin not released");
    pin_idle_a: assert property (!clockOutPinOe |-> !clockOutPin)
        else $error("clock pin active while disabled");
    halt_wake_a: assert property (haltWakeupEntry |-> ##[0:3] wakeupOscEnable)
        else $error("wake-up oscillator off at halt entry");
    ext_wake_a: assert property (startupClockOption[1] && !inCircuitCommMode |-> wakeupOscEnable)
        else $error("wake-up oscillator off with external clock");
    icc_rc_a: assert property (inCircuitCommMode |-> ##[0:8] rcOscEnable)
        else $error("internal oscillator off in circuit mode");

endmodule : otc_props

bind otc_clock_ctrl otc_props otc_props_i (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .startupClockOption(startupClockOption),
    .inCircuitCommMode(inCircuitCommMode),
    .haltWakeupEntry(haltWakeupEntry), .trimWord(trimWord),
    .rcOscEnable(rcOscEnable), .wakeupOscEnable(wakeupOscEnable),
    .clockOutPin(clockOutPin), .clockOutPinOe(clockOutPinOe)
);

// File: bench/tb_top.sv
module tb_top
    import otc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========
    // Signals and design.
    localparam logic [31:0] FT = 32'h5A01A502;
    logic              ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic              rcOscClk, wakeupOscClk, extClk, userMode;
    logic [1:0]        startupClockOption;
    logic              inCircuitCommMode, haltWakeupEntry;
    logic [9:0]        trimWord;
    logic              rcOscEnable, wakeupOscEnable, sysClk, cpuClk;
    logic              clockOutPin, clockOutPinOe;
    int                err_total, check_count, cyc, i, ns, nc;
    integer            seed;
    logic [7:0]        d;
    logic [9:0]        expq[$];

    otc_clock_ctrl #(
        .FACTORY_TRIM_H0(FT[31:24]), .FACTORY_TRIM_L0(FT[23:16]),
        .FACTORY_TRIM_H1(FT[15:8]), .FACTORY_TRIM_L1(FT[7:0])
    ) otc_clock_ctrl_i (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rcOscClk(rcOscClk),
        .wakeupOscClk(wakeupOscClk), .extClk(extClk),
        .startupClockOption(startupClockOption),
        .inCircuitCommMode(inCircuitCommMode), .userMode(userMode),
        .haltWakeupEntry(haltWakeupEntry), .trimWord(trimWord),
        .rcOscEnable(rcOscEnable), .wakeupOscEnable(wakeupOscEnable),
        .sysClk(sysClk), .cpuClk(cpuClk), .clockOutPin(clockOutPin),
        .clockOutPinOe(clockOutPinOe)
    );

    always #12.5 ref_clk = ~ref_clk;

    // The two RC oscillators only run while enabled; a hang ends the run.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        rcOscClk <= rcOscEnable & cyc[1];
        wakeupOscClk <= wakeupOscEnable & cyc[3];
        extClk <= cyc[2];
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    // ==========
    // Checking and bus tasks.
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic chk_word(input logic [31:0] g, e, input string m);
        check_count++;
        if (g !== e) begin
            $display("FAIL %0t %s got %0h exp %0h", $time, m, g, e);
            err_total++;
        end
    endtask : chk_word

    task automatic chk_bit(input logic g, e, input string m);
        chk_word({31'h0, g}, {31'h0, e}, m);
    endtask : chk_bit

    // Note layout: read flag, error flag, expected byte.
    task automatic chk_bus(input logic [9:0] e);
        chk_bit(pslverr, e[8], "bus error flag");
        if (e[9]) chk_word(prdata, {24'h0, e[7:0]}, "read data");
    endtask : chk_bus

    always @(posedge ref_clk) begin
        if (psel && penable && pready) chk_bus(expq.pop_front());
    end

    task automatic apb(input logic w, input logic [15:0] x,
                       input logic [7:0] dd, input logic [9:0] e);
        expq.push_back(e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {x, 2'b00};
        pwdata <= {24'h0, dd};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] x, input logic [7:0] dd);
        apb(1'b1, x, dd, 10'h000);
    endtask : wr

    task automatic rd(input logic [15:0] x, input logic [7:0] e);
        apb(1'b0, x, 8'h00, {2'b10, e});
    endtask : rd

    task automatic reset_dut(input logic [1:0] opt, input logic in_circuit_comm_mode);
        @(posedge ref_clk);
        rstn <= 1'b0;
        startupClockOption <= opt;
        inCircuitCommMode <= in_circuit_comm_mode;
        repeat (5) @(posedge ref_clk);
        chk_word({22'h0, trimWord}, 32'h3FC, "trim at reset");
        chk_bit(clockOutPinOe, 1'b0, "pin at reset");
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : reset_dut

    task automatic rises();
        logic ps, pc;
        ns = 0;
        nc = 0;
        repeat (512) begin
            ps = sysClk;
            pc = cpuClk;
            @(posedge ref_clk);
            ns += int'(sysClk && !ps);
            nc += int'(cpuClk && !pc);
        end
    endtask : rises

    // ==========
    // Scenarios.
    initial begin
        {ref_clk, rstn, psel, penable, pwrite, userMode} = 6'h0;
        {rcOscClk, wakeupOscClk, extClk, haltWakeupEntry} = 4'h0;
        {paddr, pwdata, startupClockOption, inCircuitCommMode} = '0;
        {err_total, check_count, cyc} = 0;
        seed = 32'h4D979B71;
        reset_dut(2'h0, 1'b0);
        rd(MAIN_CLOCK_CTRL_IDX, 8'h00);
        rd(RC_TRIM_HIGH_IDX, 8'hFF);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h04);
        for (i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            wr(RC_TRIM_HIGH_IDX, d);
            wr(SYSINT_CTRL_IDX, d);
            rd(RC_TRIM_HIGH_IDX, d);
            rd(SYSINT_CTRL_IDX, d & 8'h60);
            chk_word({22'h0, trimWord}, {22'h0, d, d[6:5]}, "trim");
        end
        wr(MAIN_CLOCK_CTRL_IDX, 8'hFF);
        rd(MAIN_CLOCK_CTRL_IDX, 8'h03);
        chk_bit(clockOutPinOe, 1'b1, "pin enabled");
        rises();
        chk_bit(nc >= 3 && nc <= 5 && ns > 100, 1'b1, "slow divide");
        wr(MAIN_CLOCK_CTRL_IDX, 8'h00);
        rises();
        chk_bit(nc + 1 >= ns && nc <= ns + 1, 1'b1, "normal clock");
        apb(1'b0, 16'h0040, 8'h00, 10'h100);
        apb(1'b1, 16'h0040, 8'h5A, 10'h100);
        userMode <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd(FACTORY_TRIM_IDX + 16'(i), FT[31-8*i -: 8]);
        end
        apb(1'b1, FACTORY_TRIM_IDX, 8'h00, 10'h100);
        rd(FACTORY_TRIM_IDX, FT[31:24]);
        userMode <= 1'b0;
        rd(FACTORY_TRIM_IDX + 16'h1, 8'h00);
        wr(CLOCK_SWITCH_CTRL_IDX, 8'h01);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h01);
        chk_bit(sysClk, 1'b1, "clock held high");
        repeat (80) @(posedge ref_clk);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h09);
        chk_bit(rcOscEnable, 1'b0, "internal osc stopped");
        wr(CLOCK_SWITCH_CTRL_IDX, 8'h00);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h08);
        repeat (120) @(posedge ref_clk);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h04);
        chk_bit(wakeupOscEnable, 1'b0, "wake-up osc stopped");
        haltWakeupEntry <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk_bit(wakeupOscEnable, 1'b1, "halt wake-up");
        haltWakeupEntry <= 1'b0;
        reset_dut(2'h1, 1'b0);
        rd(RC_TRIM_HIGH_IDX, 8'hFF);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h09);
        for (i = 2; i < 4; i++) begin
            reset_dut(2'(i), 1'b0);
            wr(CLOCK_SWITCH_CTRL_IDX, 8'h00);
            chk_bit(wakeupOscEnable, 1'b1, "external keeps wake-up");
        end
        reset_dut(2'h1, 1'b1);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h04);
        wr(CLOCK_SWITCH_CTRL_IDX, 8'h01);
        rd(CLOCK_SWITCH_CTRL_IDX, 8'h04);
        summarize();
    end

endmodule : tb_top
